// ===== hdl/wdt_pkg.sv
// constants for the i/o port watchdog timer
// assumes a 20 MHz system clock and an 8-bit i/o data path
package wdt_pkg;
   // port decode
   localparam logic [15:0] CTRL_PORT_ADDR = 16'h0443;
   localparam logic [7:0]  CMD_DISARM     = 8'h00;
   localparam logic [7:0]  CMD_REFRESH    = 8'h01;
   // status byte returned on a read
   localparam int          STAT_ARMED_BIT = 0;
   localparam int          STAT_FIRED_BIT = 1;
   localparam logic [7:0]  READ_RESET_VAL = 8'h00;
   // timing
   localparam int          CLK_HZ         = 20000000;
   localparam int          TIMEOUT_MS     = 1600;
   localparam int          TIMEOUT_CYC    = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int          CNT_W          = 25;
   localparam int          RST_PULSE_NS   = 1000;
   localparam int          RST_PULSE_CYC  = RST_PULSE_NS / (1000000000 / CLK_HZ);
   // pin bundle: addr 16, aen 1, data 8, rd_n 1, wr_n 1, strap 1
   localparam int          PIN_W          = 28;
   // watchdog states
   typedef enum logic [1:0] {
      ST_DISARMED = 2'b00,
      ST_ARMED    = 2'b01,
      ST_RESET    = 2'b10,
      ST_IRQ      = 2'b11
   } wdt_state_t;
endpackage : wdt_pkg

// ===== hdl/pin_sync_if.sv
// bundle carrying raw pin levels into the synchroniser and clean levels out
// assumes one clock domain on the clean side
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport filt (input raw, output clean);
   modport user (output raw, input clean);
endinterface : pin_sync_if

// ===== hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes pins may change at any time relative to CLK
`timescale 1ns/1ps
module pin_sync
   import wdt_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic CLK,
   input  wire logic RST,
   // pin bundle
   pin_sync_if.filt  pins
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] clean_ff;
   logic [W-1:0] nxt_clean;

   // a bit only moves once stages two and three agree, filtering glitches
   always_comb begin
      for (int i = 0; i < W; i++) begin
         nxt_clean[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : clean_ff[i];
      end
   end

   // stage one feeds stage two only
   always_ff @(posedge CLK) begin
      if (RST) begin
         s1_ff    <= '1;
         s2_ff    <= '1;
         s3_ff    <= '1;
         clean_ff <= '1;   // idle strobes are high
      end else begin
         s1_ff    <= pins.raw;
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         clean_ff <= nxt_clean;
      end
   end

   assign pins.clean = clean_ff;
endmodule : pin_sync

// ===== hdl/io_port_watchdog_timer.sv
// watchdog timer reached through one 8-bit i/o port on an isa-style bus
// assumes bus pins are asynchronous to CLK and strobes last several clocks
//
// Summary of operation
// - the first i/o read of the control port after reset arms the watchdog.
// - writing 1 to the control port arms it and restarts the interval.
// - an expired armed watchdog resets the processor or raises irq 11.
// - writing 0 to the control port disarms it with no later action.
// - the interval may stray by up to 30 percent from nominal.
// - a static board strap picks reset or interrupt as the action.
`timescale 1ns/1ps
module io_port_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // i/o bus
   input  wire logic [15:0] SA,
   input  wire logic        AEN,
   input  wire logic        IOR_N,
   input  wire logic        IOW_N,
   input  wire logic [7:0]  SD_IN,
   output logic      [7:0]  SD_OUT,
   output logic             SD_OE,
   // board strap: 1 selects interrupt, 0 selects processor reset
   input  wire logic        TIMEOUT_ACTION_STRAP,
   // timeout actions
   output logic             CPU_RESET,
   output logic             IRQ11
);
   //----------------------------------------------------------------
   // pin synchronisation
   //----------------------------------------------------------------
   pin_sync_if #(.W(PIN_W)) pins_if ();

   assign pins_if.raw = {TIMEOUT_ACTION_STRAP, IOW_N, IOR_N, SD_IN, AEN, SA};

   pin_sync #(.W(PIN_W)) u_sync (
      .CLK  (CLK),
      .RST  (RST),
      .pins (pins_if.filt)
   );

   logic [15:0] addr_s;
   logic        aen_s;
   logic [7:0]  data_s;
   logic        rd_n_s;
   logic        wr_n_s;
   logic        strap_s;

   assign {strap_s, wr_n_s, rd_n_s, data_s, aen_s, addr_s} = pins_if.clean;

   //----------------------------------------------------------------
   // port decode and strobe edges
   //----------------------------------------------------------------
   logic rd_n_d_ff;
   logic wr_n_d_ff;
   logic nxt_rd_n_d;
   logic nxt_wr_n_d;
   logic hit;
   logic rd_start;
   logic wr_start;

   // aen high means dma owns the bus, so the port must not answer
   assign hit      = (addr_s == CTRL_PORT_ADDR) && !aen_s;
   assign rd_start = hit && rd_n_d_ff && !rd_n_s;
   assign wr_start = hit && wr_n_d_ff && !wr_n_s;

   // previous strobe levels, kept for falling-edge detection
   always_comb begin
      nxt_rd_n_d = rd_n_s;
      nxt_wr_n_d = wr_n_s;
   end

   // reset to the idle high level so no false edge follows reset
   always_ff @(posedge CLK) begin
      if (RST) begin
         rd_n_d_ff <= 1'b1;
         wr_n_d_ff <= 1'b1;
      end else begin
         rd_n_d_ff <= nxt_rd_n_d;
         wr_n_d_ff <= nxt_wr_n_d;
      end
   end

   //----------------------------------------------------------------
   // watchdog state and countdown
   //----------------------------------------------------------------
   localparam logic [CNT_W-1:0] LOAD_VAL = CNT_W'(TIMEOUT_CYCLES - 1);
   localparam logic [7:0]       PULSE_LD = 8'(RST_PULSE_CYC - 1);

   wdt_state_t       state_ff;
   wdt_state_t       nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [7:0]       pulse_ff;
   logic [7:0]       nxt_pulse;
   logic             read_seen_ff;
   logic             nxt_read_seen;
   logic             fired_ff;
   logic             nxt_fired;
   logic             expire_now;

   // the counter runs out in this cycle
   assign expire_now = (state_ff == ST_ARMED) && (cnt_ff == '0);

   // a single counter sets the interval; clock accuracy is far inside 30%
   always_comb begin
      nxt_state     = state_ff;
      nxt_cnt       = cnt_ff;
      nxt_pulse     = pulse_ff;
      nxt_read_seen = read_seen_ff;
      nxt_fired     = fired_ff;
      unique case (state_ff)
         ST_DISARMED: begin
            if (rd_start && !read_seen_ff) begin
               nxt_state = ST_ARMED;
               nxt_cnt   = LOAD_VAL;
            end
         end
         ST_ARMED: begin
            if (cnt_ff == '0) begin
               nxt_fired = 1'b1;
               if (strap_s) begin
                  nxt_state = ST_IRQ;
               end else begin
                  nxt_state = ST_RESET;
                  nxt_pulse = PULSE_LD;
               end
            end else begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end
         end
         ST_RESET: begin
            // the pulse runs to its end; the system reset clears us anyway
            if (pulse_ff == '0) begin
               nxt_state = ST_DISARMED;
            end else begin
               nxt_pulse = pulse_ff - 8'h01;
            end
         end
         ST_IRQ: begin
            // the request stays up until software writes 0 or 1 to the port
         end
      endcase
      if (rd_start) begin
         nxt_read_seen = 1'b1;
      end
      // writes take priority over expiry in the same cycle, yet a clear
      // that meets an expiry leaves the fired status set
      if (wr_start && state_ff != ST_RESET) begin
         if (data_s == CMD_REFRESH) begin
            nxt_state = ST_ARMED;
            nxt_cnt   = LOAD_VAL;
            nxt_fired = expire_now;
         end else if (data_s == CMD_DISARM) begin
            nxt_state = ST_DISARMED;
            nxt_fired = expire_now;
         end
      end
   end

   // control state starts disarmed after reset
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_ff     <= ST_DISARMED;
         cnt_ff       <= '0;
         pulse_ff     <= 8'h00;
         read_seen_ff <= 1'b0;
         fired_ff     <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         pulse_ff     <= nxt_pulse;
         read_seen_ff <= nxt_read_seen;
         fired_ff     <= nxt_fired;
      end
   end

   //----------------------------------------------------------------
   // registered outputs
   //----------------------------------------------------------------
   logic [7:0] sd_out_ff;
   logic [7:0] nxt_sd_out;
   logic       sd_oe_ff;
   logic       nxt_sd_oe;
   logic       cpu_reset_ff;
   logic       nxt_cpu_reset;
   logic       irq_ff;
   logic       nxt_irq;

   // read data reflects state before this read takes effect
   always_comb begin
      nxt_sd_oe     = hit && !rd_n_s;
      nxt_sd_out    = sd_out_ff;
      if (rd_start) begin
         nxt_sd_out                 = READ_RESET_VAL;
         nxt_sd_out[STAT_ARMED_BIT] = (state_ff == ST_ARMED);
         nxt_sd_out[STAT_FIRED_BIT] = fired_ff;
      end
      nxt_cpu_reset = (nxt_state == ST_RESET);
      nxt_irq       = (nxt_state == ST_IRQ);
   end

   // every top-level output comes straight from one of these flops
   always_ff @(posedge CLK) begin
      if (RST) begin
         sd_out_ff    <= READ_RESET_VAL;
         sd_oe_ff     <= 1'b0;
         cpu_reset_ff <= 1'b0;
         irq_ff       <= 1'b0;
      end else begin
         sd_out_ff    <= nxt_sd_out;
         sd_oe_ff     <= nxt_sd_oe;
         cpu_reset_ff <= nxt_cpu_reset;
         irq_ff       <= nxt_irq;
      end
   end

   assign SD_OUT    = sd_out_ff;
   assign SD_OE     = sd_oe_ff;
   assign CPU_RESET = cpu_reset_ff;
   assign IRQ11     = irq_ff;
endmodule : io_port_watchdog_timer

// ===== bench/wdt_properties.sv
// port assertions for the watchdog
// assumes binding onto io_port_watchdog_timer
`timescale 1ns/1ps
module wdt_properties
   import wdt_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = 100
) (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST,
   // bus and pins
   input wire logic [15:0] SA,
   input wire logic        AEN,
   input wire logic        IOR_N,
   input wire logic        IOW_N,
   input wire logic [7:0]  SD_IN,
   input wire logic [7:0]  SD_OUT,
   input wire logic        SD_OE,
   input wire logic        TIMEOUT_ACTION_STRAP,
   input wire logic        CPU_RESET,
   input wire logic        IRQ11
);
   logic [15:0] quiet_ff;
   logic [15:0] nxt_quiet;
   logic        hit_wr;
   // clocks since a valid command write; bad writes must not restart it
   assign hit_wr = !IOW_N && !AEN && SA == CTRL_PORT_ADDR && SD_IN <= 8'h01;
   // saturates so a long quiet spell never wraps back to small counts
   always_comb begin
      if (RST || hit_wr) begin
         nxt_quiet = 16'h0000;
      end else if (quiet_ff == 16'hFFFF) begin
         nxt_quiet = quiet_ff;
      end else begin
         nxt_quiet = quiet_ff + 16'h0001;
      end
   end
   always_ff @(posedge CLK) quiet_ff <= nxt_quiet;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   irq_strap_a: assert property (IRQ11 |-> TIMEOUT_ACTION_STRAP)
      else $error("irq with reset strap");
   rst_strap_a: assert property ($rose(CPU_RESET) |-> !TIMEOUT_ACTION_STRAP)
      else $error("reset with irq strap");
   rst_pulse_a: assert property ($rose(CPU_RESET) |-> ##19 CPU_RESET ##1 !CPU_RESET)
      else $error("reset pulse width");
   reset_idle_a: assert property (disable iff (1'b0) RST |=> !CPU_RESET && !IRQ11 && !SD_OE)
      else $error("busy after reset");
   read_cause_a: assert property ($rose(SD_OE) |-> $past(!IOR_N, 3) && $past(!AEN, 3))
      else $error("drive without read");
   status_fmt_a: assert property (SD_OE |-> SD_OUT[7:2] == 6'h00)
      else $error("status spare bits");
   early_fire_a: assert property (($rose(CPU_RESET) || $rose(IRQ11)) |-> quiet_ff >= TIMEOUT_CYCLES - 8)
      else $error("early expiry");
   irq_clear_a: assert property ($fell(IRQ11) && !$past(RST) |-> quiet_ff < 16'h0008)
      else $error("irq fell without write");
   cover property ($rose(IRQ11));
   cover property ($rose(CPU_RESET));
   cover property ($rose(SD_OE));
endmodule : wdt_properties
bind io_port_watchdog_timer wdt_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
   .CLK(CLK), .RST(RST), .SA(SA), .AEN(AEN), .IOR_N(IOR_N), .IOW_N(IOW_N),
   .SD_IN(SD_IN), .SD_OUT(SD_OUT), .SD_OE(SD_OE), .IRQ11(IRQ11),
   .TIMEOUT_ACTION_STRAP(TIMEOUT_ACTION_STRAP), .CPU_RESET(CPU_RESET));

// ===== bench/isa_host_model.sv
// host processor issuing i/o cycles to the port
// assumes strobes of 8 clocks, 8 idle clocks after each
`timescale 1ns/1ps
module isa_host_model (
   // clock
   input  wire logic        CLK,
   // bus
   output logic      [15:0] SA,
   output logic             AEN,
   output logic             IOR_N,
   output logic             IOW_N,
   output logic      [7:0]  SD_IN,
   input  wire logic [7:0]  SD_OUT,
   input  wire logic        SD_OE
);
   initial begin
      SA = 16'h0000;
      AEN = 1'b0;
      IOR_N = 1'b1;
      IOW_N = 1'b1;
      SD_IN = 8'h00;
   end
   // one cycle; released lines show the inverse, a floating bus reads ones
   task automatic cycle(input logic wr, input logic [15:0] a,
                        input logic aen, input logic [7:0] d,
                        output logic [7:0] q);
      @(posedge CLK);
      SA <= a;
      AEN <= aen;
      SD_IN <= d;
      IOW_N <= !wr;
      IOR_N <= wr;
      repeat (8) @(posedge CLK);
      q = SD_OE ? SD_OUT : 8'hFF;
      IOW_N <= 1'b1;
      IOR_N <= 1'b1;
      SD_IN <= ~d;
      SA <= ~a;
      repeat (8) @(posedge CLK);
   endtask : cycle
endmodule : isa_host_model

// ===== bench/io_port_watchdog_timer_bench.sv
// self-checking bench: host model drives the port, pins vs a model
// assumes a 100-clock interval so each expiry is short
`timescale 1ns/1ps
module io_port_watchdog_timer_bench
   import wdt_pkg::*;
;
   localparam int TO = 100;
   logic        clk;
   logic        rst;
   logic        strap;
   logic [15:0] sa;
   logic [7:0]  sd_in, sd_out, q;
   logic        aen, ior_n, iow_n, sd_oe, cpu_reset, irq;
   int          fail_count = 0, n_tests = 0, f, cyc = 0, armed, fired;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ceiling well above the roughly 1400 clocks of the run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         report_and_stop();
      end
   end
   io_port_watchdog_timer #(.TIMEOUT_CYCLES(TO)) DUT (
      .CLK(clk), .RST(rst), .SA(sa), .AEN(aen), .IOR_N(ior_n),
      .IOW_N(iow_n), .SD_IN(sd_in), .SD_OUT(sd_out), .SD_OE(sd_oe),
      .TIMEOUT_ACTION_STRAP(strap), .CPU_RESET(cpu_reset), .IRQ11(irq));
   isa_host_model host (
      .CLK(clk), .SA(sa), .AEN(aen), .IOR_N(ior_n), .IOW_N(iow_n),
      .SD_IN(sd_in), .SD_OUT(sd_out), .SD_OE(sd_oe));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // port access; the model applies the command effect
   task automatic acc(input logic wr, input logic [7:0] d);
      host.cycle(wr, CTRL_PORT_ADDR, 1'b0, d, q);
      if (wr && d <= 8'h01) begin
         armed = int'(d);
         fired = 0;
      end
   endtask : acc
   // clocks until an action pin is high, -1 if none within n
   task automatic watch(input int n, output int first);
      first = -1;
      for (int i = 0; i < n && first < 0; i++) begin
         @(posedge clk);
         if (irq === 1'b1 || cpu_reset === 1'b1) first = i;
      end
      if (first >= 0) begin
         armed = 0;
         // any expiry sets the fired status, whatever the strap picks
         fired = 1;
      end
   endtask : watch
   // one expiry, pre clocks already gone since the reload
   task automatic expire(input int pre);
      watch(2 * TO, f);
      check(8'(f + pre >= 70 && f + pre <= 130), 8'h01);
      check({6'h00, cpu_reset, irq}, {6'h00, !strap, strap});
   endtask : expire
   initial begin
      rst <= 1'b1;
      strap <= 1'b1;
      void'($urandom(32'hC151));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      watch(2 * TO, f);
      check(8'(f + 1), 8'h00);
      acc(1'b0, 8'h00);
      armed = 1;
      acc(1'b0, 8'h00);
      check(q, 8'(armed));
      expire(27);
      acc(1'b0, 8'h00);
      check(q & 8'h02, 8'(fired << 1));
      acc(1'b1, CMD_REFRESH);
      check({7'h00, irq}, 8'h00);
      // host refreshes well inside the interval
      repeat (4) begin
         watch($urandom_range(60, 30), f);
         check(8'(f + 1), 8'h00);
         acc(1'b1, CMD_REFRESH);
      end
      acc(1'b1, 8'($urandom_range(255, 2)));
      expire(27);
      acc(1'b1, CMD_REFRESH);
      host.cycle(1'b1, CTRL_PORT_ADDR, 1'b1, CMD_DISARM, q);
      host.cycle(1'b1, CTRL_PORT_ADDR ^ 16'($urandom_range(255, 1)), 1'b0,
                 CMD_DISARM, q);
      expire(43);
      acc(1'b1, CMD_DISARM);
      watch(3 * TO, f);
      check(8'(f + 1), 8'h00);
      strap <= 1'b0;
      acc(1'b1, CMD_REFRESH);
      expire(11);
      repeat (25) @(posedge clk);
      acc(1'b0, 8'h00);
      check(q, 8'({fired[0], armed[0]}));
      // a second reset mid-run: disarmed again, and the next read re-arms
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      armed = 0;
      fired = 0;
      acc(1'b0, 8'h00);
      check(q, 8'({fired[0], armed[0]}));
      armed = 1;
      acc(1'b0, 8'h00);
      check(q, 8'({fired[0], armed[0]}));
      expire(27);
      report_and_stop();
   end
   task automatic report_and_stop();
      if (fail_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
endmodule : io_port_watchdog_timer_bench
